// ===== hdl/usr_pkg.sv
// Constants shared by the four-bit universal shift register block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit bus.
package usr_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_CMD    = 8'h04;
  localparam logic [7:0]  OFS_STATE  = 8'h08;
  localparam logic [7:0]  OFS_FIFO   = 8'h0c;
  localparam logic [7:0]  OFS_DIV    = 8'h10;
  localparam logic [7:0]  OFS_STEPS  = 8'h14;

  // Control field positions
  localparam int          CTRL_RUN   = 0;
  localparam int          CTRL_PINS  = 1;
  localparam logic [1:0]  CTRL_RESET = 2'h0;

  // Command word fields: {select high, select low, left serial, right serial, parallel[3:0]}
  localparam int          CMD_W      = 8;
  localparam int          CMD_SEL_HI = 7;
  localparam int          CMD_SEL_LO = 6;
  localparam int          CMD_LEFT   = 5;
  localparam int          CMD_RIGHT  = 4;

  // Status field positions of the fifo and state registers
  localparam int          FIFO_EMPTY = 8;
  localparam int          FIFO_FULL  = 9;
  localparam int          STATE_CLR  = 4;

  // Mode select codes {high, low}
  localparam logic [1:0]  MODE_HOLD  = 2'h0;
  localparam logic [1:0]  MODE_RIGHT = 2'h1;
  localparam logic [1:0]  MODE_LEFT  = 2'h2;
  localparam logic [1:0]  MODE_LOAD  = 2'h3;

  // Step clock divider: 10 MHz / (DIV + 1)
  localparam logic [15:0] DIV_RESET  = 16'h0009;
  localparam int          FIFO_DEPTH = 8;
endpackage : usr_pkg

// ===== hdl/usr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [WIDTH-1:0]           in_data,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (level != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : usr_fifo

// ===== hdl/usr4_core.sv
// Four-stage shift register with hold, right shift, left shift and load.
// Assumes a step enable on clk and a clear that is asynchronous and overriding.
`timescale 1ns/1ps
module usr4_core
  import usr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       clear_any,
  input  wire logic       step,
  input  wire logic [1:0] mode,
  input  wire logic       left_in,
  input  wire logic       right_in,
  input  wire logic [3:0] par_in,
  output logic [3:0]      q
);
  // Bit 0 is the first stage, bit 3 the last
  always_ff @(posedge clk or posedge clear_any) begin
    if (clear_any) begin
      q <= 4'h0;
    end else if (step) begin
      unique case (mode)
        MODE_HOLD:  q <= q;
        MODE_RIGHT: q <= {q[2:0], right_in};
        MODE_LEFT:  q <= {left_in, q[3:1]};
        MODE_LOAD:  q <= par_in;
      endcase
    end
  end
endmodule : usr4_core

// ===== hdl/usr4_top.sv
// Universal shift register block with a classic Wishbone register port.
// Operation
// - four state bits drive four ordered outputs
// - low clear forces all outputs low immediately
// - both selects high loads parallel inputs
// - load ignores both serial inputs
// - low select only shifts toward last stage
// - high select only shifts toward first stage
// - both selects low holds all bits
// - changes only on step clock rising edge
// - shifts use values from before edge
// Commands come from an 8-deep fifo fed by software, or from synchronised pins.
// Assumes clk at 10 MHz and a single-cycle classic Wishbone master.
`timescale 1ns/1ps
module usr4_top
  import usr_pkg::*;
#(
  parameter int FIFO_W = CMD_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        async_clear_n,
  input  wire logic        mode_select_low,
  input  wire logic        mode_select_high,
  input  wire logic        right_shift_serial_in,
  input  wire logic        left_shift_serial_in,
  input  wire logic [3:0]  parallel_in,
  output logic             out_stage_first,
  output logic             out_stage_second,
  output logic             out_stage_third,
  output logic             out_stage_last
);
  localparam int LW = $clog2(FIFO_D + 1);

  logic [1:0]        ctrl;
  logic [15:0]       div;
  logic [15:0]       div_cnt;
  logic              tick;
  logic [31:0]       steps;
  logic              clear_any;
  logic              clr_meta;
  logic              clr_sync;
  logic [7:0]        pin_meta;
  logic [7:0]        pin_sync;
  logic [3:0]        q;
  logic              req;
  logic              cmd_wr;
  logic              stall;
  logic              fifo_in_ready;
  logic [FIFO_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [LW-1:0]     fifo_level;
  logic              step;
  logic [7:0]        cmd;
  logic [31:0]       next_dat;

  // Clear acts without the clock; release is resynchronised before steps resume
  assign clear_any = rst | ~async_clear_n;

  always_ff @(posedge clk or posedge clear_any) begin
    if (clear_any) begin
      clr_meta <= 1'b1;
      clr_sync <= 1'b1;
    end else begin
      clr_meta <= 1'b0;
      clr_sync <= clr_meta;
    end
  end

  // Pin-sourced command, two flops deep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= {mode_select_high, mode_select_low, left_shift_serial_in,
                   right_shift_serial_in, parallel_in};
      pin_sync <= pin_meta;
    end
  end

  // Step clock: one-cycle enable every div+1 cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= DIV_RESET;
    end else if (div_cnt == 16'h0000) begin
      div_cnt <= div;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  assign tick = (div_cnt == 16'h0000);

  // A step is one rising edge of the emulated shift clock
  assign fifo_pop = tick & ctrl[CTRL_RUN] & ~ctrl[CTRL_PINS] & ~clr_sync;
  assign step     = tick & ctrl[CTRL_RUN] & ~clr_sync & (ctrl[CTRL_PINS] | fifo_valid);
  assign cmd      = ctrl[CTRL_PINS] ? pin_sync : fifo_data;

  usr_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (dat_i[FIFO_W-1:0]),
    .in_valid  (cmd_wr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  usr4_core u_core (
    .clk       (clk),
    .clear_any (clear_any),
    .step      (step),
    .mode      ({cmd[CMD_SEL_HI], cmd[CMD_SEL_LO]}),
    .left_in   (cmd[CMD_LEFT]),
    .right_in  (cmd[CMD_RIGHT]),
    .par_in    (cmd[3:0]),
    .q         (q)
  );

  assign out_stage_first  = q[0];
  assign out_stage_second = q[1];
  assign out_stage_third  = q[2];
  assign out_stage_last   = q[3];

  // Wishbone slave: one wait cycle, writes to a full fifo wait for space
  assign req    = cyc_i & stb_i & ~ack_o;
  assign cmd_wr = req & we_i & (adr_i == OFS_CMD) & sel_i[0];
  assign stall  = cmd_wr & ~fifo_in_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~stall;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (req && we_i && adr_i == OFS_CTRL && sel_i[0]) begin
      ctrl <= dat_i[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= DIV_RESET;
    end else if (req && we_i && adr_i == OFS_DIV) begin
      if (sel_i[0]) begin
        div[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        div[15:8] <= dat_i[15:8];
      end
    end
  end

  // Step counter: a step in the clearing cycle still counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      steps <= 32'h0000_0000;
    end else if (req && we_i && adr_i == OFS_STEPS && sel_i[0]) begin
      steps <= step ? 32'h0000_0001 : 32'h0000_0000;
    end else if (step) begin
      steps <= steps + 32'h0000_0001;
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      OFS_CTRL:  next_dat = {30'h0000_0000, ctrl};
      OFS_STATE: next_dat = {27'h000_0000, clr_sync, q};
      OFS_FIFO:  next_dat = {22'h00_0000, ~fifo_in_ready, ~fifo_valid, 4'h0, 4'(fifo_level)};
      OFS_DIV:   next_dat = {16'h0000, div};
      OFS_STEPS: next_dat = steps;
      default:   next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= next_dat;
    end
  end
endmodule : usr4_top

// ===== test/usr_pins_model.sv
// Stand-in for the logic driving the pin side of the shift register.
// Assumes the bench raises clear_req to ask for an overriding clear,
// and raises hold to put its own command word on the pins instead of the pattern.
`timescale 1ns/1ps
module usr_pins_model (
  input  wire logic       clk,
  input  wire logic       clear_req,
  input  wire logic       hold,
  input  wire logic [7:0] word,
  output logic            async_clear_n,
  output logic            mode_select_low,
  output logic            mode_select_high,
  output logic            right_shift_serial_in,
  output logic            left_shift_serial_in,
  output logic [3:0]      parallel_in
);
  logic [7:0] pat = 8'h00;
  initial {async_clear_n, mode_select_high, mode_select_low, left_shift_serial_in,
           right_shift_serial_in, parallel_in} = 9'h100;
  // Pins move just after an edge, then hold until the next one
  always @(posedge clk) begin
    pat           <= pat + 8'h1d;
    async_clear_n <= !clear_req;
    {mode_select_high, mode_select_low, left_shift_serial_in, right_shift_serial_in, parallel_in} <= hold ? word : pat;
  end
endmodule : usr_pins_model

// ===== test/usr4_monitor.sv
// Bus and clear checks at the ports of the shift register block.
// Assumes it is bound into usr4_top.
`timescale 1ns/1ps
module usr4_monitor
  import usr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        async_clear_n,
  input wire logic        out_stage_first,
  input wire logic        out_stage_second,
  input wire logic        out_stage_third,
  input wire logic        out_stage_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] q;
  assign q = {out_stage_last, out_stage_third, out_stage_second, out_stage_first};
  property p_clr; !async_clear_n |-> q == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("stages not cleared");
  property p_rel; $rose(async_clear_n) |-> q == 4'h0 ##1 q == 4'h0; endproperty
  a_rel: assert property (p_rel) else $error("step right after clear");
  property p_ack1; ack_o |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_fast; cyc_i && stb_i && !ack_o && adr_i != OFS_CMD |=> ack_o; endproperty
  a_fast: assert property (p_fast) else $error("late ack");
  property p_unm; ack_o && !we_i && adr_i > OFS_STEPS |-> dat_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_cmdr; ack_o && !we_i && adr_i == OFS_CMD |-> dat_o == 32'h0; endproperty
  a_cmdr: assert property (p_cmdr) else $error("command read not zero");
  property p_hold; ack_o && we_i |-> $stable(dat_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved on write");
  c_clr: cover property (!async_clear_n);
  c_rd: cover property (ack_o && !we_i && adr_i == OFS_STATE);
  c_cmd: cover property (ack_o && we_i && adr_i == OFS_CMD);
endmodule : usr4_monitor
bind usr4_top usr4_monitor usr4_monitor_i (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .async_clear_n(async_clear_n), .out_stage_first(out_stage_first),
  .out_stage_second(out_stage_second), .out_stage_third(out_stage_third), .out_stage_last(out_stage_last));

// ===== test/universal_shift_register_4bit_bench.sv
// Self-checking bench: fifo-fed commands, clear, bus decode.
// Assumes the pin model drives every pin; reads are checked from a queue.
`timescale 1ns/1ps
module universal_shift_register_4bit_bench
  import usr_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ack_o, clear_req, cl_n, ml, mh, rs, ls, o0, o1, o2, o3, hold;
  logic [7:0]  adr, c, word;
  logic [3:0]  sel, pin, q;
  logic [31:0] dat, dat_o;
  logic [31:0] eq[$], mq[$];
  int          err_total, n_checks, cyc_n;
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  usr4_top usr4_top_i (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .async_clear_n(cl_n), .mode_select_low(ml), .mode_select_high(mh),
    .right_shift_serial_in(rs), .left_shift_serial_in(ls), .parallel_in(pin), .out_stage_first(o0),
    .out_stage_second(o1), .out_stage_third(o2), .out_stage_last(o3));
  usr_pins_model usr_pins_model_i (.clk(clk), .clear_req(clear_req), .hold(hold), .word(word),
    .async_clear_n(cl_n), .mode_select_low(ml),
    .mode_select_high(mh), .right_shift_serial_in(rs), .left_shift_serial_in(ls), .parallel_in(pin));
  function automatic logic [3:0] nx(input logic [3:0] s, input logic [7:0] k);
    case (k[7:6])
      MODE_RIGHT: nx = {s[2:0], k[CMD_RIGHT]};
      MODE_LEFT:  nx = {k[CMD_LEFT], s[3:1]};
      MODE_LOAD:  nx = k[3:0];
      default:    nx = s;
    endcase
  endfunction : nx
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge clk);
    while (ack_o !== 1'b1) @(posedge clk);
    cyc <= 0;
    stb <= 0;
  endtask : wb
  always @(posedge clk) begin
    if (ack_o === 1'b1 && eq.size() > 0) begin
      chk("bus read", dat_o & mq[0], eq[0] & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h7cc7));
    {rst, cyc, stb, we, adr, sel, dat, clear_req, q, hold, word} = {1'b1, 61'h0};
    repeat (8) @(posedge clk);
    rst <= 0;
    wb(1, OFS_DIV, 0, 0, 0);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      c = 8'($urandom);
      if (i < 4) c[7:6] = 2'(3 - i);
      q = nx(q, c);
      wb(1, OFS_CMD, {24'h0, c}, 0, 0);
    end
    wb(0, OFS_FIFO, 0, 32'h208, 32'h30f);
    wb(1, OFS_CTRL, 1, 0, 0);
    repeat (20) @(posedge clk);
    wb(0, OFS_STATE, 0, {28'h0, q}, 32'h1f);
    wb(0, OFS_STEPS, 0, 8, 32'hffff);
    wb(0, OFS_FIFO, 0, 32'h100, 32'h30f);
    wb(0, OFS_CMD, 0, 0, '1);
    wb(1, 8'h18, 32'h5a, 0, 0);
    wb(0, 8'h18, 0, 0, '1);
    clear_req <= 1;
    repeat (4) @(posedge clk);
    wb(0, OFS_STATE, 0, 32'h10, 32'h1f);
    wb(1, OFS_CMD, 32'hc5, 0, 0);
    repeat (3) @(posedge clk);
    chk("stages in clear", {28'h0, o3, o2, o1, o0}, 0);
    clear_req <= 0;
    repeat (8) @(posedge clk);
    chk("stages loaded", {28'h0, o3, o2, o1, o0}, 32'h5);
    // Pin source: commands pass the two-flop synchroniser, one step per cycle
    {hold, word} <= 9'h1fa;
    wb(1, OFS_CTRL, 3, 0, 0);
    repeat (6) @(posedge clk);
    chk("pin load", {28'h0, o3, o2, o1, o0}, 32'ha);
    word <= 8'h50;
    repeat (10) @(posedge clk);
    chk("pin right fill", {28'h0, o3, o2, o1, o0}, 32'hf);
    word <= 8'h80;
    repeat (10) @(posedge clk);
    chk("pin left fill", {28'h0, o3, o2, o1, o0}, 32'h0);
    word <= 8'hc5;
    repeat (10) @(posedge clk);
    word <= 8'h3a;
    repeat (10) @(posedge clk);
    chk("pin hold", {28'h0, o3, o2, o1, o0}, 32'h5);
    wb(0, OFS_STATE, 0, 32'h5, 32'h1f);
    results();
  end
endmodule : universal_shift_register_4bit_bench
